//--- rtl/sos_pkg.sv
package sos_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned SOS_CLK_HZ = 125_000_000;
   localparam int unsigned SOS_MS_PER_S = 1000;
   localparam int unsigned SOS_MS_CYCLES = SOS_CLK_HZ / SOS_MS_PER_S;
   localparam int unsigned SOS_LED_COUNT = 12;
   localparam int unsigned SOS_WALK_STEP_MS = 200;
   localparam int unsigned SOS_WALK_END_MS = SOS_LED_COUNT * SOS_WALK_STEP_MS;
   localparam int unsigned SOS_VERSION_MS = 1500;
   localparam int unsigned SOS_VER_A_END_MS = SOS_WALK_END_MS + SOS_VERSION_MS;
   localparam int unsigned SOS_VER_B_END_MS = SOS_VER_A_END_MS + SOS_VERSION_MS;
   localparam int unsigned SOS_POWERUP_MS = 7000;
   localparam int unsigned SOS_FLASH_BIT = 7;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses within the slave's window
   localparam logic [11:0] SOS_CTRL_ADDR = 12'h000;
   localparam logic [11:0] SOS_STATUS_ADDR = 12'h004;
   localparam logic [11:0] SOS_VERSION_ADDR = 12'h008;
   localparam logic [11:0] SOS_AUDIO_ADDR = 12'h00C;
   localparam logic [7:0] SOS_CTRL_RESET = 8'h04;
   localparam logic [1:0] SOS_HTRANS_NONSEQ = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Video
   localparam int unsigned SOS_VID_W = 20;
   localparam logic [19:0] SOS_GRAY_WORD = 20'h8_0200;
   localparam logic [1:0] SOS_RATE_HD = 2'h1;
   localparam logic [1:0] SOS_RATE_3G = 2'h2;
   localparam logic [20:0] SOS_PIX_720 = 21'h0E_1000;
   localparam logic [20:0] SOS_PIX_1080 = 21'h1F_A400;

   typedef enum logic [1:0] {
      SOS_ST_POWERUP = 2'b00,
      SOS_ST_PASS = 2'b01,
      SOS_ST_GRAY = 2'b10,
      SOS_ST_IMAGE = 2'b11
   } sos_state_type;

   typedef struct packed {
      logic valid;
      logic [SOS_VID_W-1:0] data;
   } sos_video_type;

   // Bit order matches the CTRL register, bit 0 last
   typedef struct packed {
      logic board_link_ok;
      logic usb_transfer_active;
      logic fmt_1080;
      logic [2:0] gray_hold_interval;
      logic reference_timing_only_mode;
      logic optical_select;
   } sos_ctrl_type;

   typedef struct packed {
      logic status;
      logic coax;
      logic optical;
      logic done;
   } sos_board_led_type;

endpackage : sos_pkg

//--- rtl/sos_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sos_sync #(
   parameter int unsigned W = 4
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   import sos_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sos_sync_state_type;

   sos_sync_state_type r_reg;
   sos_sync_state_type r_next;

   // A bit changes only once stages two and three agree
   always_comb begin
      r_next = r_reg;
      r_next.s1 = async_in;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.q = (r_reg.s3 & ~(r_reg.s2 ^ r_reg.s3)) | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sync_out = r_reg.q;

endmodule : sos_sync
`default_nettype wire

//--- rtl/sos_output_select.sv
// Operation
// R1: After power-up, light all twelve front indicators one after another.
// R2: Then show firmware version patterns, then hold power indicator on.
// R3: USB indicator dark unless drive attached and transfer in progress.
// R4: Input indicator lit while selected input carries valid video.
// R5: Data indicator toggles on each bus message addressed to this module.
// R6: Audio indicator lit only while de-embedding and its channel has signal.
// R7: Board status flashes during power-up, then steady while boards communicate.
// R8: Coaxial board indicator lit only if coaxial selected and valid.
// R9: Optical board indicator lit only if optical selected and valid.
// R10: Configuration-done indicator lit once logic is configured and running.
// R11: After power-up enable outputs; route valid selected input to outputs.
// R12: Without valid input, gray for configured interval, then stored image.
// R13: Power-up sequence lasts about seven seconds before output source acts.
// R14: While compatible input is recognised, generator idle and input passed.
// R15: Optical output always carries the same stream as coaxial output.
// R16: Generated image is 720 or 1080 lines per stored format value.
// R17: HD and 3G rate inputs count as compatible.
// R18: Both fixed images read from nonvolatile storage while generating.
// R19: Gray interval is 0 to 7 whole seconds; 0 skips gray.
// R20: Reference-only mode always sends the generated image to outputs.
// R21: Losing input during pass-through restarts gray interval, then image.
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sos_output_select #(
   parameter int unsigned MS_CYCLES = sos_pkg::SOS_MS_CYCLES,
   parameter logic [11:0] FW_VERSION_A = 12'h021,
   parameter logic [11:0] FW_VERSION_B = 12'h022
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic coax_valid_pin,
   input wire logic optical_valid_pin,
   input wire logic usb_attached_pin,
   input wire logic config_done_pin,
   input wire logic [1:0] coax_rate,
   input wire logic [1:0] optical_rate,
   input wire sos_pkg::sos_video_type coax_video,
   input wire sos_pkg::sos_video_type optical_video,
   input wire logic bus_addr_hit,
   input wire logic deembed_active,
   input wire logic [7:0] audio_present,
   output logic img_rd_en,
   output logic img_sel_1080,
   output logic [20:0] img_rd_addr,
   input wire logic [sos_pkg::SOS_VID_W-1:0] img_rd_data,
   output logic vid_out_en,
   output sos_pkg::sos_video_type coax_out,
   output sos_pkg::sos_video_type optical_out,
   output logic [11:0] front_led,
   output sos_pkg::sos_board_led_type board_led
);
   import sos_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      sos_state_type st;
      logic [16:0] ms_div;
      logic [12:0] ms_cnt;
      logic [7:0] step_cnt;
      logic [3:0] walk_idx;
      sos_ctrl_type ctrl;
      logic wr_pend;
      logic [11:0] wr_addr;
      logic [31:0] rdata;
      logic [20:0] pix;
      logic img_pend;
      sos_video_type vid;
      logic vid_en;
      logic [11:0] fled;
      sos_board_led_type bled;
      logic data_led;
   } sos_core_type;

   sos_core_type r_reg;
   sos_core_type r_next;

   logic [3:0] pins_sync;
   logic coax_ok;
   logic optical_ok;
   logic sel_valid;
   logic pass_ok;
   logic tick;
   logic pu_done;
   logic [12:0] hold_ms;
   logic [20:0] pix_last;
   logic ahb_take;
   logic [11:0] ahb_off;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   sos_sync #(
      .W(4)
   ) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .async_in({config_done_pin, usb_attached_pin, optical_valid_pin, coax_valid_pin}),
      .sync_out(pins_sync)
   );

   function automatic logic rate_ok(input logic [1:0] rate);
      rate_ok = (rate == SOS_RATE_HD) || (rate == SOS_RATE_3G);  // see R17
   endfunction : rate_ok

   ////////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      r_next = r_reg;
      coax_ok = pins_sync[0] && rate_ok(coax_rate);
      optical_ok = pins_sync[1] && rate_ok(optical_rate);
      sel_valid = r_reg.ctrl.optical_select ? optical_ok : coax_ok;
      // Reference-only keeps the input for timing, never as picture
      pass_ok = sel_valid && !r_reg.ctrl.reference_timing_only_mode;  // see R14, R20
      tick = (r_reg.ms_div == 17'(MS_CYCLES - 1));
      pu_done = (r_reg.st != SOS_ST_POWERUP);
      hold_ms = 13'(r_reg.ctrl.gray_hold_interval) * 13'(SOS_MS_PER_S);  // see R19
      pix_last = r_reg.ctrl.fmt_1080 ? (SOS_PIX_1080 - 21'd1) : (SOS_PIX_720 - 21'd1);  // see R16
      ahb_take = hsel && hready && (htrans == SOS_HTRANS_NONSEQ);
      ahb_off = {haddr[11:2], 2'b00};

      r_next.ms_div = tick ? 17'd0 : r_reg.ms_div + 17'd1;

      // Every timed step moves on the one-millisecond enable pulse, so the
      // whole power-up needs only narrow counters instead of one wide one

      ////////////////////////////////////////////////////////////////////////////////
      // Source sequencing
      // The power-up phase owns ms_cnt; later states reuse it for the gray hold
      case (r_reg.st)
         SOS_ST_POWERUP: begin
            if (tick) begin
               r_next.ms_cnt = r_reg.ms_cnt + 13'd1;
               if (r_reg.walk_idx < 4'(SOS_LED_COUNT)) begin
                  if (r_reg.step_cnt == 8'(SOS_WALK_STEP_MS - 1)) begin
                     r_next.step_cnt = 8'd0;
                     r_next.walk_idx = r_reg.walk_idx + 4'd1;  // see R1
                  end else begin
                     r_next.step_cnt = r_reg.step_cnt + 8'd1;
                  end
               end
               if (r_reg.ms_cnt == 13'(SOS_POWERUP_MS - 1)) begin  // see R13
                  r_next.ms_cnt = 13'd0;
                  if (pass_ok) begin
                     r_next.st = SOS_ST_PASS;  // see R11
                  end else if (r_reg.ctrl.gray_hold_interval == 3'd0 ||
                               r_reg.ctrl.reference_timing_only_mode) begin
                     r_next.st = SOS_ST_IMAGE;
                  end else begin
                     r_next.st = SOS_ST_GRAY;  // see R12
                  end
               end
            end
         end

         // A lost input restarts the hold from zero, never from a stale count
         SOS_ST_PASS: begin
            if (!pass_ok) begin
               r_next.ms_cnt = 13'd0;
               if (r_reg.ctrl.gray_hold_interval == 3'd0 ||
                   r_reg.ctrl.reference_timing_only_mode) begin
                  r_next.st = SOS_ST_IMAGE;  // see R19, R20
               end else begin
                  r_next.st = SOS_ST_GRAY;  // see R21
               end
            end
         end

         // Compared with >= so that a shorter hold written mid-interval ends it
         SOS_ST_GRAY: begin
            if (pass_ok) begin
               r_next.st = SOS_ST_PASS;
            end else if (r_reg.ms_cnt >= hold_ms ||
                         r_reg.ctrl.reference_timing_only_mode) begin
               r_next.st = SOS_ST_IMAGE;  // see R12
               r_next.ms_cnt = 13'd0;
            end else if (tick) begin
               r_next.ms_cnt = r_reg.ms_cnt + 13'd1;
            end
         end

         SOS_ST_IMAGE: begin
            if (pass_ok) begin
               r_next.st = SOS_ST_PASS;  // see R14
            end
         end

         default: begin
            r_next.st = SOS_ST_POWERUP;
         end
      endcase


      ////////////////////////////////////////////////////////////////////////////////
      // Image readout runs only while the stored image is on air
      // The store answers one cycle late, so valid trails the state by a cycle
      r_next.img_pend = (r_reg.st == SOS_ST_IMAGE);  // see R18
      if (r_reg.st == SOS_ST_IMAGE) begin
         r_next.pix = (r_reg.pix >= pix_last) ? 21'd0 : r_reg.pix + 21'd1;
      end else begin
         r_next.pix = 21'd0;
      end


      ////////////////////////////////////////////////////////////////////////////////
      // Output stream; no seamless changeover is attempted
      // Downstream gear sees a short break whenever the stored image takes over
      r_next.vid_en = pu_done;  // see R11
      case (r_reg.st)
         SOS_ST_PASS: begin
            r_next.vid = r_reg.ctrl.optical_select ? optical_video : coax_video;  // see R11
         end
         SOS_ST_GRAY: begin
            r_next.vid.valid = 1'b1;
            r_next.vid.data = SOS_GRAY_WORD;  // see R12
         end
         SOS_ST_IMAGE: begin
            r_next.vid.valid = r_reg.img_pend;
            r_next.vid.data = img_rd_data;  // see R18
         end
         default: begin
            r_next.vid = '0;
         end
      endcase


      ////////////////////////////////////////////////////////////////////////////////
      // Indicators
      // The walk and version patterns own the front row until power-up is over
      if (bus_addr_hit) begin
         r_next.data_led = !r_reg.data_led;  // see R5
      end
      if (!pu_done) begin
         if (r_reg.walk_idx < 4'(SOS_LED_COUNT)) begin
            r_next.fled = 12'h001 << r_reg.walk_idx;  // see R1
         end else if (r_reg.ms_cnt < 13'(SOS_VER_A_END_MS)) begin
            r_next.fled = FW_VERSION_A;  // see R2
         end else if (r_reg.ms_cnt < 13'(SOS_VER_B_END_MS)) begin
            r_next.fled = FW_VERSION_B;  // see R2
         end else begin
            r_next.fled = 12'h001;
         end
         r_next.bled.status = r_reg.ms_cnt[SOS_FLASH_BIT];  // see R7
      end else begin
         r_next.fled[0] = 1'b1;  // see R2
         r_next.fled[1] = pins_sync[2] && r_reg.ctrl.usb_transfer_active;  // see R3
         r_next.fled[2] = sel_valid;  // see R4
         r_next.fled[3] = r_reg.data_led;  // see R5
         r_next.fled[11:4] = audio_present & {8{deembed_active && sel_valid}};  // see R6
         r_next.bled.status = r_reg.ctrl.board_link_ok;  // see R7
      end
      r_next.bled.coax = !r_reg.ctrl.optical_select && coax_ok;  // see R8
      r_next.bled.optical = r_reg.ctrl.optical_select && optical_ok;  // see R9
      r_next.bled.done = pins_sync[3];  // see R10


      ////////////////////////////////////////////////////////////////////////////////
      // Bus slave: zero wait states, read data registered in the address phase
      // A read right after a control write still sees the old control word
      r_next.wr_pend = ahb_take && hwrite;
      r_next.wr_addr = ahb_off;
      if (r_reg.wr_pend && r_reg.wr_addr == SOS_CTRL_ADDR) begin
         r_next.ctrl = sos_ctrl_type'(hwdata[7:0]);
      end
      if (ahb_take && !hwrite) begin
         case (ahb_off)
            SOS_CTRL_ADDR: begin
               r_next.rdata = {24'h00_0000, r_reg.ctrl};
            end
            SOS_STATUS_ADDR: begin
               r_next.rdata = {11'h000, r_reg.fled, r_reg.bled, r_reg.vid_en,
                               pu_done, sel_valid, r_reg.st};
            end
            SOS_VERSION_ADDR: begin
               r_next.rdata = {8'h00, FW_VERSION_B, FW_VERSION_A};
            end
            SOS_AUDIO_ADDR: begin
               r_next.rdata = {23'h00_0000, deembed_active, audio_present};
            end
            default: begin
               r_next.rdata = 32'h0000_0000;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r_reg <= '0;
         r_reg.st <= SOS_ST_POWERUP;
         r_reg.ctrl <= sos_ctrl_type'(SOS_CTRL_RESET);
      end else begin
         r_reg <= r_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Outputs

   // Only single word transfers are expected, so no wait state is ever needed
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = r_reg.rdata;
   assign img_rd_en = (r_reg.st == SOS_ST_IMAGE);
   assign img_sel_1080 = r_reg.ctrl.fmt_1080;  // see R16
   assign img_rd_addr = r_reg.pix;
   assign vid_out_en = r_reg.vid_en;
   assign coax_out = r_reg.vid;
   // Both outputs share one register, so they can never drift apart
   assign optical_out = r_reg.vid;  // see R15
   assign front_led = r_reg.fled;
   assign board_led = r_reg.bled;

endmodule : sos_output_select
`default_nettype wire

//--- testbench/sos_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sos_monitor #(
   parameter int unsigned MS_CYCLES = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic config_done_pin,
   input wire logic deembed_active,
   input wire logic img_rd_en,
   input wire logic img_sel_1080,
   input wire logic [20:0] img_rd_addr,
   input wire logic vid_out_en,
   input wire sos_pkg::sos_video_type coax_out,
   input wire sos_pkg::sos_video_type optical_out,
   input wire logic [11:0] front_led,
   input wire sos_pkg::sos_board_led_type board_led
);
   import sos_pkg::*;
   // One tick of slack either way: the ms divider phase is not visible here
   localparam int unsigned UP_LO = (SOS_POWERUP_MS - 1) * MS_CYCLES;
   localparam int unsigned UP_HI = (SOS_POWERUP_MS + 1) * MS_CYCLES;
   logic [31:0] up_reg;
   logic [31:0] up_next;
   always_comb up_next = (up_reg == '1) ? up_reg : up_reg + 32'h0000_0001;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         up_reg <= '0;
      end else begin
         up_reg <= up_next;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   AST_EN_EARLY: assert property (vid_out_en |-> up_reg >= UP_LO)
      else $error("outputs enabled too early");
   AST_EN_LATE: assert property (up_reg == UP_HI |-> vid_out_en)
      else $error("outputs not enabled after power-up");
   AST_OPT_COPY: assert property (optical_out == coax_out)
      else $error("optical output differs from coax output");
   AST_PWR_LED: assert property (vid_out_en && $past(vid_out_en) |-> front_led[0])
      else $error("power indicator dark after power-up");
   AST_AUD_OFF: assert property ((vid_out_en && !deembed_active) [*3] |=> front_led[11:4] == 8'h00)
      else $error("audio indicator lit without de-embedding");
   AST_DONE: assert property (config_done_pin [*6] |=> board_led.done)
      else $error("done indicator dark");
   AST_ADDR720: assert property (img_rd_en && !img_sel_1080 |-> img_rd_addr < SOS_PIX_720)
      else $error("720 image address out of range");
   AST_ADDR1080: assert property (img_rd_en |-> img_rd_addr < SOS_PIX_1080)
      else $error("1080 image address out of range");
   AST_ADDR_STEP: assert property (img_rd_en && $past(img_rd_en) && $stable(img_sel_1080)
      && img_rd_addr != 21'h0_0000 |-> img_rd_addr == $past(img_rd_addr) + 21'h0_0001)
      else $error("image read address did not advance");
endmodule : sos_monitor
bind sos_output_select sos_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (.hclk, .hresetn,
   .config_done_pin, .deembed_active, .img_rd_en, .img_sel_1080, .img_rd_addr, .vid_out_en,
   .coax_out, .optical_out, .front_led, .board_led);
`default_nettype wire

//--- testbench/sos_source.sv
`timescale 1ns/1ps
`default_nettype none
module sos_source (
   input wire logic hclk,
   input wire logic coax_on,
   input wire logic opt_on,
   input wire logic [20:0] img_rd_addr,
   output logic coax_valid_pin,
   output logic optical_valid_pin,
   output sos_pkg::sos_video_type coax_video,
   output sos_pkg::sos_video_type optical_video,
   output logic [19:0] img_rd_data
);
   import sos_pkg::*;
   logic [19:0] cnt_reg;
   initial begin
      cnt_reg = 20'h0_0000;
      coax_valid_pin = 1'b0;
      optical_valid_pin = 1'b0;
      coax_video = '0;
      optical_video = '0;
      img_rd_data = 20'h0_0000;
   end
   // An absent source shows a changing pattern, never the last good word
   always @(posedge hclk) begin
      cnt_reg <= cnt_reg + 20'h0_0001;
      coax_valid_pin <= coax_on;
      optical_valid_pin <= opt_on;
      coax_video <= {coax_on, coax_on ? cnt_reg : ~cnt_reg};
      optical_video <= {opt_on, opt_on ? cnt_reg ^ 20'hF_0000 : ~cnt_reg};
      img_rd_data <= img_rd_addr[19:0] ^ 20'h5_5555;
   end
endmodule : sos_source
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import sos_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
   logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
   logic [1:0] htrans = 2'h0, coax_rate = SOS_RATE_HD, optical_rate = SOS_RATE_HD;
   logic [2:0] hsize = 3'h2;
   logic usb_attached_pin = 1'b0, config_done_pin = 1'b1, bus_addr_hit = 1'b0, b;
   logic deembed_active = 1'b0, coax_on = 1'b1, opt_on = 1'b0;
   logic coax_valid_pin, optical_valid_pin, img_rd_en, img_sel_1080, vid_out_en;
   logic [7:0] audio_present = 8'h00;
   logic [20:0] img_rd_addr;
   logic [19:0] img_rd_data;
   logic [11:0] front_led;
   sos_video_type coax_video, optical_video, coax_out, optical_out, d;
   sos_board_led_type board_led;
   int error_cnt = 0, n_compared = 0, cyc = 0, tmo = 0, tn = 0;
   // Version codes are arbitrary
   sos_output_select #(.MS_CYCLES(10), .FW_VERSION_A(12'h123), .FW_VERSION_B(12'h456)) uut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
      .hresp, .hrdata, .coax_valid_pin, .optical_valid_pin, .usb_attached_pin, .config_done_pin,
      .coax_rate, .optical_rate, .coax_video, .optical_video, .bus_addr_hit, .deembed_active,
      .audio_present, .img_rd_en, .img_sel_1080, .img_rd_addr, .img_rd_data, .vid_out_en,
      .coax_out, .optical_out, .front_led, .board_led);
   sos_source u_src (.hclk, .coax_on, .opt_on, .img_rd_addr, .coax_valid_pin,
      .optical_valid_pin, .coax_video, .optical_video, .img_rd_data);
   assign hready = hreadyout;
   always #4 hclk = ~hclk;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : complete_run
   // Limit covers the 7 s power-up plus one 1 s gray hold, with margin
   always @(posedge hclk) begin
      cyc <= hresetn ? cyc + 1 : 0;
      tmo <= tmo + 1;
      if (tmo == 95000) begin
         error_cnt++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(posedge hclk);
   endtask : w
   task automatic upto(input int t);
      while (cyc < t) @(posedge hclk);
   endtask : upto
   task automatic tend();
      tn++;
      $display("test %0d finished", tn);
   endtask : tend
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {20'h0_0000, a};
      hwrite <= wr;
      htrans <= SOS_HTRANS_NONSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask : bus
   // The idle edge avoids the read-after-write hazard on the control word
   task automatic ctl(input logic [31:0] v);
      bus(1'b1, SOS_CTRL_ADDR, v);
      w(1);
   endtask : ctl
   task automatic st(input logic [1:0] e);
      bus(1'b0, SOS_STATUS_ADDR, 32'h0000_0000);
      chk({30'h0000_0000, rd[1:0]}, e, "state");
   endtask : st
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      w(8);
      hresetn <= 1'b1;
      bus(1'b0, SOS_CTRL_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_0004, "ctrl reset");
      bus(1'b0, SOS_VERSION_ADDR, 32'h0000_0000);
      chk(rd, 32'h0045_6123, "version");
      bus(1'b0, 12'h010, 32'h0000_0000);
      chk(rd, 32'h0000_0000, "unmapped");
      ctl(32'h0000_0084);
      bus(1'b0, SOS_CTRL_ADDR, 32'h0000_0000);
      chk(rd, 32'h0000_0084, "ctrl rw");
      st(2'h0);
      for (int k = 0; k < 12; k++) begin
         upto(k * 2000 + 1000);
         chk(front_led, 12'h001 << k, "walk");
      end
      upto(31000);
      chk(front_led, 12'h123, "version a");
      upto(46000);
      chk(front_led, 12'h456, "version b");
      upto(60000);
      chk(vid_out_en, 1'b0, "early enable");
      chk(front_led, 12'h001, "power only");
      tend();
      upto(70100);
      st(2'h1);
      chk(vid_out_en, 1'b1, "enable");
      @(posedge hclk);
      d = coax_video;
      @(posedge hclk);
      chk(coax_out, d, "pass");
      chk(front_led[2], 1'b1, "input led");
      chk(board_led, 4'hD, "board leds");
      for (int i = 0; i < 2; i++) begin
         b = front_led[3];
         bus_addr_hit <= 1'b1;
         w(1);
         bus_addr_hit <= 1'b0;
         w(3);
         chk(front_led[3], !b, "data led");
      end
      usb_attached_pin <= 1'b1;
      w(8);
      chk(front_led[1], 1'b0, "usb idle");
      ctl(32'h0000_00C4);
      w(4);
      chk(front_led[1], 1'b1, "usb busy");
      usb_attached_pin <= 1'b0;
      w(8);
      chk(front_led[1], 1'b0, "usb gone");
      deembed_active <= 1'b1;
      audio_present <= 8'hA5;
      w(4);
      chk(front_led[11:4], 8'hA5, "audio");
      deembed_active <= 1'b0;
      tend();
      ctl(32'h0000_0085);
      w(8);
      st(2'h2);
      chk(coax_out.data, SOS_GRAY_WORD, "gray");
      chk(board_led, 4'h9, "coax unselected");
      chk(front_led[2], 1'b0, "input led off");
      opt_on <= 1'b1;
      w(8);
      st(2'h1);
      chk(board_led, 4'hB, "optical led");
      optical_rate <= 2'h3;
      w(4);
      st(2'h2);
      optical_rate <= SOS_RATE_3G;
      w(4);
      st(2'h1);
      tend();
      coax_on <= 1'b0;
      ctl(32'h0000_0084);
      tn = cyc;
      upto(tn + 9000);
      st(2'h2);
      upto(tn + 10200);
      tn = 3;
      st(2'h3);
      chk(img_sel_1080, 1'b0, "720 image");
      @(posedge hclk);
      chk(coax_out.data, (img_rd_addr[19:0] - 20'h0_0002) ^ 20'h5_5555, "image word");
      ctl(32'h0000_00A4);
      w(4);
      chk(img_sel_1080, 1'b1, "1080 image");
      tend();
      coax_on <= 1'b1;
      w(8);
      st(2'h1);
      ctl(32'h0000_0080);
      coax_on <= 1'b0;
      w(8);
      st(2'h3);
      coax_on <= 1'b1;
      ctl(32'h0000_0082);
      w(8);
      st(2'h3);
      chk(front_led[2], 1'b1, "input led ref");
      tend();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
